//--- src/stereo_sync_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef STEREO_SYNC_MAP_SVH
`define STEREO_SYNC_MAP_SVH

// ==========================================================
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_PERIOD      8'h04
`define REG_WIDTH       8'h08
`define REG_TIME        8'h0c
`define REG_SEQ         8'h10
`define REG_REPLAY_LEN  8'h14
`define REG_STATUS      8'h18
`define REG_MATRIX      8'h40
`define REG_MATRIX_END  8'h7c

// ==========================================================
// Control field positions
`define CTRL_TRIG_EN_LO 0
`define CTRL_SYNC_SEL   2
`define CTRL_SOURCE_LO  4

// ==========================================================
// Reset values
`define RST_TRIG_EN     2'h3
`define RST_PERIOD      32'h0032_dcd5
`define RST_WIDTH       32'h0000_03e8
`define RST_REPLAY_LEN  16'h0010

// ==========================================================
// Timing and stream format
`define US_NS           1000
`define CLK_NS          10
`define US_CYCLES       (`US_NS / `CLK_NS)
`define DISP_INVALID    12'hfff
`define DISP_FRAC_BITS  4
`define MATRIX_WORDS    16

`endif

//--- src/stereo_pkg.sv
// Types shared by the trigger, sync and disparity output logic
package stereo_pkg;

	typedef enum logic [2:0] {
		ST_IDLE, ST_TIME, ST_SEQ, ST_MATRIX, ST_FIRST, ST_PIXEL
	} phase_t;

	typedef enum logic [1:0] {
		SRC_CAMERA, SRC_REPLAY, SRC_NETWORK, SRC_SPARE
	} source_t;

	typedef enum logic [1:0] {
		KIND_TIME, KIND_SEQ, KIND_MATRIX, KIND_PIXEL
	} kind_t;

	typedef struct packed {
		logic        sof;
		logic        eof;
		logic        invalid;
		logic [7:0]  left;
		logic [11:0] disp;
	} pixel_in_t;

	typedef struct packed {
		kind_t       kind;
		logic        last;
		logic [31:0] data;
	} word_t;

	typedef struct packed {
		phase_t            phase;
		logic [1:0]        trig_en;
		logic              sync_sel;
		source_t           source;
		logic [31:0]       period;
		logic [31:0]       width;
		logic [31:0]       tick;
		logic [1:0]        trig;
		logic [1:0]        trig_oe;
		logic              sync_meta;
		logic              sync_lvl;
		logic              sync_prev;
		logic [6:0]        presc;
		logic [31:0]       time_us;
		logic [31:0]       frame_time;
		logic [31:0]       frame_seq;
		logic [31:0]       seq;
		logic [15:0]       replay_len;
		logic [15:0]       replay_idx;
		logic [15:0][31:0] matrix;
		logic [3:0]        mat_idx;
		pixel_in_t         held;
		word_t             out_w;
		logic              out_v;
		word_t             skid_w;
		logic              skid_v;
		logic              in_ready;
		logic [31:0]       rdata;
	} state_t;

endpackage

//--- src/stereo_trigger_sync_disparity_out.sv
// Camera triggers, timestamp sync and disparity result stream framing
//
// Summary of operation
// - Two camera trigger outputs, each with its own enable, sharing one period and width.
// - Triggers are active high; idle level is low.
// - Pulse width and period come from software registers.
// - Sync select turns trigger 1 pin into an input, trigger 1 off.
// - In sync mode each rising sync edge clears the timestamp to zero.
// - Replay source loops the stored sequence index forever, wrapping.
// - Stereo output carries the rectified left pixel with each disparity.
// - Disparity is the horizontal offset seen from the left camera.
// - Disparity is 12 bits, low 4 bits fraction; divide by 16.
// - Rejected disparities are sent as all ones, 0xfff.
// - Every map is preceded by the reprojection matrix words.
// - Each frame carries a timestamp and a sequence: microsecond receive time and own count, or host stamps for network source.
// - Timestamp starts at zero after reset without any sync.
`timescale 1ns/1ps
`include "stereo_sync_map.svh"

module stereo_trigger_sync_disparity_out
(
	// Clock, reset, enable
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	// Register port
	input  wire logic [7:0]           addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic [31:0]               rdata,
	// Trigger pins, pin 1 is two-way
	output logic [1:0]                trig_o,
	output logic [1:0]                trig_oe,
	input  wire logic                 trig1_i,
	// Incoming matched pixels
	input  wire stereo_pkg::pixel_in_t in_pix,
	input  wire logic                 in_valid,
	output logic                      in_ready,
	// Host supplied stamps for network images
	input  wire logic [31:0]          net_time,
	input  wire logic [31:0]          net_seq,
	// Result stream
	output stereo_pkg::word_t         out_word,
	output logic                      out_valid,
	input  wire logic                 out_ready,
	// Replay position
	output logic [15:0]               replay_idx
);

	stereo_pkg::state_t s;
	stereo_pkg::state_t next_s;
	logic [1:0]         pulse_on;
	logic               tick_wrap;
	logic               sync_edge;
	logic               us_wrap;
	logic               push;
	stereo_pkg::word_t  push_w;
	logic               frame_end;
	logic [7:0]         waddr;
	logic [3:0]         mat_sel;

	// ==========================================================
	// Trigger pulse shaping
	// Period and width apply at once, so a write may cut one pulse
	assign tick_wrap = (s.tick >= s.period - 32'h1);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_trig
			// Width below period keeps both edges inside every period
			assign pulse_on[gi] = s.trig_en[gi]
				&& (s.tick < s.width) && (s.width != 32'h0);
		end
	endgenerate

	assign sync_edge = s.sync_sel && s.sync_lvl && !s.sync_prev;
	// Prescaler divides the clock down to one microsecond
	assign us_wrap   = (s.presc == 7'(`US_CYCLES - 1));
	assign mat_sel   = 4'(addr[5:2]);

	// ==========================================================
	// Next state
	always_comb
	begin
		next_s    = s;
		push      = 1'b0;
		push_w    = '0;
		frame_end = 1'b0;
		waddr     = addr;

		// Shared period counter
		next_s.tick = tick_wrap ? 32'h0 : s.tick + 32'h1;
		next_s.trig = pulse_on;
		next_s.trig_oe = 2'h3;
		if (s.sync_sel)
		begin
			next_s.trig[1]    = 1'b0;
			next_s.trig_oe[1] = 1'b0;
		end

		// Sync synchroniser and timestamp
		// Pin is asynchronous: two flops before anything reads it
		next_s.sync_meta = trig1_i;
		next_s.sync_lvl  = s.sync_meta;
		next_s.sync_prev = s.sync_lvl;
		next_s.presc     = us_wrap ? 7'h0 : s.presc + 7'h1;
		if (us_wrap)
			next_s.time_us = s.time_us + 32'h1;
		if (sync_edge)
		begin
			next_s.time_us = 32'h0;
			next_s.presc   = 7'h0;
		end

		// Result stream framing
		case (s.phase)
			stereo_pkg::ST_IDLE:
			begin
				// Non-sof words in idle are dropped until a frame starts
				if (in_valid && s.in_ready && in_pix.sof)
				begin
					next_s.held  = in_pix;
					next_s.phase = stereo_pkg::ST_TIME;
					if (s.source == stereo_pkg::SRC_NETWORK)
					begin
						next_s.frame_time = net_time;
						next_s.frame_seq  = net_seq;
					end
					else
					begin
						next_s.frame_time = s.time_us;
						next_s.frame_seq  = s.seq;
					end
				end
			end
			stereo_pkg::ST_TIME:
			begin
				push        = !s.skid_v;
				push_w.kind = stereo_pkg::KIND_TIME;
				push_w.data = s.frame_time;
				if (push)
					next_s.phase = stereo_pkg::ST_SEQ;
			end
			stereo_pkg::ST_SEQ:
			begin
				push        = !s.skid_v;
				push_w.kind = stereo_pkg::KIND_SEQ;
				push_w.data = s.frame_seq;
				if (push)
				begin
					next_s.phase   = stereo_pkg::ST_MATRIX;
					next_s.mat_idx = 4'h0;
				end
			end
			stereo_pkg::ST_MATRIX:
			begin
				push        = !s.skid_v;
				push_w.kind = stereo_pkg::KIND_MATRIX;
				push_w.data = s.matrix[s.mat_idx];
				if (push)
				begin
					next_s.mat_idx = s.mat_idx + 4'h1;
					if (s.mat_idx == 4'(`MATRIX_WORDS - 1))
						next_s.phase = stereo_pkg::ST_FIRST;
				end
			end
			stereo_pkg::ST_FIRST:
			begin
				push        = !s.skid_v;
				push_w.kind = stereo_pkg::KIND_PIXEL;
				push_w.last = s.held.eof;
				push_w.data = {12'h000, s.held.left,
					s.held.invalid ? `DISP_INVALID : s.held.disp};
				if (push)
				begin
					next_s.phase = s.held.eof ? stereo_pkg::ST_IDLE
						: stereo_pkg::ST_PIXEL;
					frame_end    = s.held.eof;
				end
			end
			stereo_pkg::ST_PIXEL:
			begin
				push        = in_valid && s.in_ready;
				push_w.kind = stereo_pkg::KIND_PIXEL;
				push_w.last = in_pix.eof;
				// Raw 12-bit value passes untouched unless invalid, fraction in low bits
				push_w.data = {12'h000, in_pix.left,
					in_pix.invalid ? `DISP_INVALID : in_pix.disp};
				if (push && in_pix.eof)
				begin
					next_s.phase = stereo_pkg::ST_IDLE;
					frame_end    = 1'b1;
				end
			end
			default:
			begin
				next_s.phase   = stereo_pkg::ST_IDLE;
				next_s.mat_idx = 4'h0;
			end
		endcase

		if (frame_end)
		begin
			next_s.seq = s.seq + 32'h1;
			if (s.source == stereo_pkg::SRC_REPLAY)
				next_s.replay_idx = (s.replay_idx + 16'h1 >= s.replay_len)
					? 16'h0 : s.replay_idx + 16'h1;
		end

		// Two-entry buffer: output register plus skid register
		// Skid slot fills only while the output register is still held
		if (s.out_v && out_ready)
		begin
			next_s.out_v  = s.skid_v;
			next_s.out_w  = s.skid_w;
			next_s.skid_v = 1'b0;
		end
		if (push)
		begin
			if (!next_s.out_v)
			begin
				next_s.out_v = 1'b1;
				next_s.out_w = push_w;
			end
			else
			begin
				next_s.skid_v = 1'b1;
				next_s.skid_w = push_w;
			end
		end
		// Ready only with a free skid slot, so a stall never drops a word
		next_s.in_ready = !next_s.skid_v
			&& (next_s.phase == stereo_pkg::ST_IDLE
			|| next_s.phase == stereo_pkg::ST_PIXEL);

		// Register writes
		if (wr)
		begin
			case (waddr)
				`REG_CTRL:
				begin
					next_s.trig_en  = wdata[`CTRL_TRIG_EN_LO +: 2];
					next_s.sync_sel = wdata[`CTRL_SYNC_SEL];
					next_s.source   =
						stereo_pkg::source_t'(wdata[`CTRL_SOURCE_LO +: 2]);
				end
				`REG_TIME, `REG_SEQ, `REG_STATUS:
				begin
					// Read only, a write here is dropped
				end
				`REG_PERIOD: next_s.period = wdata;
				`REG_WIDTH: next_s.width = wdata;
				`REG_REPLAY_LEN:
				begin
					next_s.replay_len = wdata[15:0];
					next_s.replay_idx = 16'h0;
				end
				default:
				begin
					if (waddr >= `REG_MATRIX && waddr <= `REG_MATRIX_END)
						next_s.matrix[mat_sel] = wdata;
				end
			endcase
		end

		// Register reads, data stand one cycle later
		next_s.rdata = 32'h0;
		if (rd)
		begin
			case (addr)
				`REG_CTRL:
					next_s.rdata = {26'h0, s.source, 1'b0, s.sync_sel,
						s.trig_en};
				`REG_PERIOD: next_s.rdata = s.period;
				`REG_WIDTH: next_s.rdata = s.width;
				`REG_TIME: next_s.rdata = s.time_us;
				`REG_SEQ: next_s.rdata = s.seq;
				`REG_REPLAY_LEN: next_s.rdata = {16'h0, s.replay_len};
				`REG_STATUS:
					next_s.rdata = {s.replay_idx, 8'h0, s.out_v, s.skid_v,
						s.sync_lvl, 2'h0, 3'(s.phase)};
				default:
				begin
					if (addr >= `REG_MATRIX && addr <= `REG_MATRIX_END)
						next_s.rdata = s.matrix[mat_sel];
				end
			endcase
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s            <= '0;
			s.phase      <= stereo_pkg::ST_IDLE;
			s.source     <= stereo_pkg::SRC_CAMERA;
			s.trig_en    <= `RST_TRIG_EN;
			s.period     <= `RST_PERIOD;
			s.width      <= `RST_WIDTH;
			s.replay_len <= `RST_REPLAY_LEN;
			s.time_us    <= 32'h0;
			s.seq        <= 32'h0;
			s.presc      <= 7'h0;
			// Sync flops low match the idle pin, so no false edge
			s.sync_meta  <= 1'b0;
			s.sync_lvl   <= 1'b0;
			s.sync_prev  <= 1'b0;
			s.sync_sel   <= 1'b0;
			// Pins stay released and low until the first enabled cycle
			s.trig       <= 2'h0;
			s.trig_oe    <= 2'h0;
			s.out_v      <= 1'b0;
			s.skid_v     <= 1'b0;
			s.in_ready   <= 1'b0;
			s.replay_idx <= 16'h0;
			s.rdata      <= 32'h0;
		end
		else if (ce)
		begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs
	assign rdata      = s.rdata;
	assign trig_o     = s.trig;
	assign trig_oe    = s.trig_oe;
	assign in_ready   = s.in_ready;
	assign out_word   = s.out_w;
	assign out_valid  = s.out_v;
	assign replay_idx = s.replay_idx;

endmodule

//--- dv/stereo_out_sva.sv
// Assertion checker for trigger, register read and result stream ports
`timescale 1ns/1ps
module stereo_out_sva
(
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  ce,
	// Register read
	input wire logic                  rd,
	input wire logic [31:0]           rdata,
	// Trigger pins
	input wire logic [1:0]            trig_o,
	input wire logic [1:0]            trig_oe,
	// Streams
	input wire stereo_pkg::pixel_in_t in_pix,
	input wire logic                  in_valid,
	input wire logic                  in_ready,
	input wire stereo_pkg::word_t     out_word,
	input wire logic                  out_valid,
	input wire logic                  out_ready
);
	// ==========
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_trig1_released: assert property (!trig_oe[1] |-> !trig_o[1])
		else $error("trigger 1 driven while released");
	a_trig0_idle: assert property (!trig_oe[0] |-> !trig_o[0])
		else $error("trigger 0 high while not driven");
	a_trig_reset: assert property (!$past(rst_n) |-> trig_o == 2'h0)
		else $error("trigger high straight after reset");
	a_trig0_driven: assert property ($past(ce) && $past(rst_n) |-> trig_oe[0])
		else $error("trigger 0 not driven");
	a_rdata_idle: assert property (!$past(rd) && $past(ce) |-> rdata == 32'h0)
		else $error("read data outside its cycle");
	a_out_hold: assert property (ce && out_valid && !out_ready
		|=> out_valid && $stable(out_word))
		else $error("stalled word changed");
	a_pix_width: assert property (out_valid
		&& out_word.kind == stereo_pkg::KIND_PIXEL
		|-> out_word.data[31:20] == 12'h0)
		else $error("pixel word upper bits set");
	a_last_pixel: assert property (out_valid && out_word.last
		|-> out_word.kind == stereo_pkg::KIND_PIXEL)
		else $error("last flag on header word");
	a_header_gap: assert property (ce && in_valid && in_ready && in_pix.sof
		|=> !in_ready [*8])
		else $error("input taken during header");
endmodule

bind stereo_trigger_sync_disparity_out stereo_out_sva u_sva
(
	.clk(clk), .rst_n(rst_n), .ce(ce), .rd(rd), .rdata(rdata),
	.trig_o(trig_o), .trig_oe(trig_oe), .in_pix(in_pix),
	.in_valid(in_valid), .in_ready(in_ready), .out_word(out_word),
	.out_valid(out_valid), .out_ready(out_ready)
);

//--- dv/result_sink.sv
// Result receiver model, prompt or stalling at random
`timescale 1ns/1ps
module result_sink
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pace select
	input wire logic slow,
	// Stream handshake
	output logic     out_ready
);
	// ==========
	// Stall pattern
	logic [15:0] lf;
	always @(posedge clk)
	begin
		lf <= !rst_n ? 16'hace1
			: {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		out_ready <= rst_n && (!slow || (lf[0] && lf[3]));
	end
endmodule

//--- dv/tb_top.sv
// Self-checking bench for triggers, sync and result stream
`timescale 1ns/1ps
`include "stereo_sync_map.svh"
module tb_top;
	// ==========
	// Signals
	logic                  clk, rst_n, wr, rd, trig1_i, in_valid, slow, ce;
	logic                  in_ready, out_valid, out_ready;
	logic [7:0]            addr;
	logic [31:0]           wdata, rdata, seed, rv, net_time, net_seq;
	logic [1:0]            trig_o, trig_oe;
	logic [15:0]           replay_idx;
	stereo_pkg::pixel_in_t in_pix;
	stereo_pkg::word_t     out_word;
	stereo_pkg::word_t     q [$];
	logic [31:0]           pix [$];
	logic [31:0]           mat [16];
	int                    num_errors, num_checks, j, p;

	stereo_trigger_sync_disparity_out dut
	(
		.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .trig_o(trig_o),
		.trig_oe(trig_oe), .trig1_i(trig1_i), .in_pix(in_pix),
		.in_valid(in_valid), .in_ready(in_ready), .net_time(net_time),
		.net_seq(net_seq), .out_word(out_word), .out_valid(out_valid),
		.out_ready(out_ready), .replay_idx(replay_idx)
	);
	result_sink sink
	(
		.clk(clk), .rst_n(rst_n), .slow(slow), .out_ready(out_ready)
	);

	always #5 clk = ~clk;
	always @(posedge clk)
		if (out_valid === 1'b1 && out_ready === 1'b1)
			q.push_back(out_word);

	// ==========
	// Helpers
	function automatic logic [31:0] lfsr32(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] exp_pix(input stereo_pkg::pixel_in_t x);
		return {12'h0, x.left, x.invalid ? `DISP_INVALID : x.disp};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hang;
		num_errors++;
		close_out();
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	// Waits for a rising pulse, then follows two whole periods
	task automatic trig_run(input int pd, input int w, input logic [1:0] en);
		int i;
		reg_wr(`REG_WIDTH, w);
		reg_wr(`REG_PERIOD, pd);
		reg_wr(`REG_CTRL, {30'h0, en});
		// Let the new settings reach the pins before watching them
		repeat (2) @(posedge clk);
		i = 0;
		while (trig_o[0] !== 1'b0 && i < 100)
		begin
			@(posedge clk);
			i++;
		end
		while (trig_o[0] !== 1'b1 && i < 200)
		begin
			@(posedge clk);
			i++;
		end
		if (i >= 200)
			hang();
		for (i = 0; i < 2 * pd; i++)
		begin
			check(trig_o[0], i % pd < w);
			check(trig_o[1], en[1] && i % pd < w);
			@(posedge clk);
		end
	endtask
	task automatic pulse;
		@(posedge clk);
		trig1_i <= 1'b1;
		repeat (5) @(posedge clk);
		trig1_i <= 1'b0;
	endtask
	task automatic frame(input int n, input logic [31:0] sq,
		input logic [31:0] tm, input logic chk_tm);
		int i;
		stereo_pkg::pixel_in_t x;
		@(posedge clk);
		for (i = 0; i < n; i++)
		begin
			seed = lfsr32(seed);
			x = {i == 0, i == n - 1, seed[24] & seed[25], seed[15:8],
				i == 1 ? 12'hfff : seed[11:0]};
			in_pix <= x;
			in_valid <= 1'b1;
			pix.push_back(exp_pix(x));
			j = 0;
			do
			begin
				@(posedge clk);
				j++;
			end
			while (in_ready !== 1'b1 && j < 500);
			if (j >= 500)
				hang();
		end
		in_valid <= 1'b0;
		for (j = 0; j < 2000 && q.size() < n + 18; j++)
			@(posedge clk);
		if (j >= 2000)
			hang();
		check(q[0].kind, stereo_pkg::KIND_TIME);
		if (chk_tm)
			check(q[0].data, tm);
		check(q[1].kind, stereo_pkg::KIND_SEQ);
		check(q[1].data, sq);
		for (i = 0; i < 16; i++)
		begin
			check(q[2 + i].kind, stereo_pkg::KIND_MATRIX);
			check(q[2 + i].data, mat[i]);
		end
		for (i = 0; i < n; i++)
		begin
			check(q[18 + i].kind, stereo_pkg::KIND_PIXEL);
			check(q[18 + i].data, pix[i]);
			check(q[18 + i].last, i == n - 1);
		end
		q.delete();
		pix.delete();
	endtask

	// ==========
	// Main sequence
	initial
	begin
		clk = 0;
		rst_n = 0;
		{wr, rd, trig1_i, in_valid, slow} = 5'h0;
		ce = 1'b1;
		net_time = 32'h0;
		net_seq = 32'h0;
		addr = 8'h0;
		wdata = 32'h0;
		in_pix = '0;
		seed = 32'h49e6fb36;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		reg_rd(`REG_TIME, rv);
		check(rv, 0);
		reg_rd(8'h20, rv);
		check(rv, 0);
		for (j = 0; j < 3; j++)
		begin
			seed = lfsr32(seed);
			p = 2 + seed[2:0];
			trig_run(p, 1 + seed[5:3] % (p - 1), 2'b11);
		end
		trig_run(5, 2, 2'b01);
		repeat (100) @(posedge clk);
		pulse();
		reg_rd(`REG_TIME, rv);
		check(rv != 0, 1);
		reg_wr(`REG_CTRL, 32'h7);
		repeat (3) @(posedge clk);
		check(trig_oe, 2'b01);
		pulse();
		reg_rd(`REG_TIME, rv);
		check(rv, 0);
		repeat (200) @(posedge clk);
		reg_rd(`REG_TIME, rv);
		check(rv, 2);
		ce <= 1'b0;
		repeat (150) @(posedge clk);
		ce <= 1'b1;
		reg_rd(`REG_TIME, rv);
		check(rv, 2);
		reg_wr(`REG_CTRL, 32'h3);
		for (p = 0; p < `MATRIX_WORDS; p++)
		begin
			seed = lfsr32(seed);
			mat[p] = seed;
			reg_wr(8'(`REG_MATRIX + 4 * p), seed);
		end
		reg_rd(`REG_MATRIX + 8'h0c, rv);
		check(rv, mat[3]);
		slow <= 1'b1;
		for (p = 0; p < 4; p++)
		begin
			if (p == 1)
			begin
				reg_wr(`REG_REPLAY_LEN, 32'h2);
				reg_wr(`REG_CTRL, 32'h13);
			end
			frame(3 + p, p, 32'h0, 1'b0);
			if (p > 0)
				check(replay_idx, p % 2);
		end
		seed = lfsr32(seed);
		net_time <= seed;
		net_seq <= ~seed;
		reg_wr(`REG_CTRL, 32'h23);
		frame(5, ~seed, seed, 1'b1);
		check(replay_idx, 1);
		close_out();
	end
endmodule
